//--- core/swpl_limit.sv
// Software position limit: limit settings, range check and command clamp
// Overview of operation
// [R01] Upper and lower limit settings are held, both zero after reset.
// [R02] Length or pulse units: limit active only when upper exceeds lower.
// [R03] Degree unit: arc runs counter-clockwise lower to upper, active unless equal.
// [R04] Degree settings of 360.000 and above are reduced modulo 360.000.
// [R05] Degree settings from -0.001 to -359.999 get 360.000 added.
// [R06] Degree settings of -360.000 and below: remainder plus 360.000 defines arc.
// [R07] Outside the degree arc, only the shortest way back is allowed.
// [R08] Limits are positions measured from machine home, address zero.
// [R09] A command below the active minimum is replaced by the minimum.
// [R10] A command above the active maximum is replaced by the maximum.
// [R11] Controller writes to object subentries 01h and 02h update the limits.
// [R12] Minimum greater than maximum disables the whole limit function; code does so in length or pulse units only.
// [R13] Warning while clamping; cleared by a command in reverse direction.
// [R14] Command beyond 32 bits or 30 bits past a limit raises alarm, erases home; code checks the 30 bits in length or pulse units only.
// [R15] Applies only in csp, pp, point table and jog; bypassed during homing; code keeps the 32-bit range alarm in every mode.
// [R16] Checks run once per command update with wide signed arithmetic.
`timescale 1ns/1ns
`default_nettype none
module swpl_limit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Servo parameter writes
  input wire logic parWrEn,
  input wire logic parWrSel,
  input wire logic [swpl_pkg::POS_W-1:0] parWrData,
  // Object writes from the motion controller
  input wire logic objWrEn,
  input wire logic [15:0] objWrIndex,
  input wire logic [7:0] objWrSub,
  input wire logic [swpl_pkg::POS_W-1:0] objWrData,
  // Setting readback
  output logic [swpl_pkg::POS_W-1:0] upperPositionLimitSetting,
  output logic [swpl_pkg::POS_W-1:0] lowerPositionLimitSetting,
  // Operating context
  input wire logic [3:0] positionUnitSelect,
  input wire logic [2:0] opMode,
  input wire logic alarmClr,
  // Command in, current position
  input wire logic cmdValid,
  input wire logic signed [swpl_pkg::CMD_W-1:0] cmdPos,
  input wire logic signed [swpl_pkg::POS_W-1:0] curPos,
  // Command out and status
  output logic outValid,
  output logic signed [swpl_pkg::POS_W-1:0] outPos,
  output logic limitActive,
  output logic positiveLimitSymbol,
  output logic negativeLimitSymbol,
  output logic limitClampWarning,
  output logic commandRangeAlarm,
  output logic homeErase
);
  import swpl_pkg::*;

  // Fold any degree value into 0 .. 359.999
  function automatic logic signed [CMD_W-1:0] normDeg(input logic signed [CMD_W-1:0] v);
    logic signed [CMD_W-1:0] r;
    r = v % DEG_TURN;
    if (r < 0) begin
      r = r + DEG_TURN;
    end
    return r;
  endfunction : normDeg

  // True when p lies on the arc from lo counter-clockwise to hi
  function automatic logic inArc(input logic signed [CMD_W-1:0] p,
                                 input logic signed [CMD_W-1:0] lo,
                                 input logic signed [CMD_W-1:0] hi);
    logic r;
    if (lo <= hi) begin
      r = (p >= lo) && (p <= hi);
    end else begin
      r = (p >= lo) || (p <= hi);
    end
    return r;
  endfunction : inArc

  logic [POS_W-1:0] upper_r;
  logic [POS_W-1:0] lower_r;
  logic signed [CMD_W-1:0] prevCmd_r;
  swpl_warn_t warn_r;
  swpl_warn_t warn_nxt;
  logic outValid_r;
  logic signed [POS_W-1:0] outPos_r;
  logic limitActive_r;
  logic posHit_r;
  logic negHit_r;
  logic alarm_r;
  logic homeErase_r;

  // Limit settings, shared by parameter and object writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      upper_r <= UPPER_LIMIT_RST; // R01
      lower_r <= LOWER_LIMIT_RST; // R01
    end else begin
      // Controller object write overrides a same-cycle parameter write
      if (objWrEn && objWrIndex == OBJ_LIMIT_INDEX && objWrSub == OBJ_SUB_MAX) begin
        upper_r <= objWrData; // R11
      end else if (parWrEn && parWrSel == PAR_SEL_UPPER) begin
        upper_r <= parWrData;
      end
      if (objWrEn && objWrIndex == OBJ_LIMIT_INDEX && objWrSub == OBJ_SUB_MIN) begin
        lower_r <= objWrData; // R11
      end else if (parWrEn && parWrSel == PAR_SEL_LOWER) begin
        lower_r <= parWrData;
      end
    end
  end

  // Settings widened to command width, measured from home
  logic signed [CMD_W-1:0] upW;
  logic signed [CMD_W-1:0] loW;
  logic signed [CMD_W-1:0] upDeg;
  logic signed [CMD_W-1:0] loDeg;
  logic degMode;
  logic modeOk;
  logic active;
  assign upW = CMD_W'($signed(upper_r)); // R08
  assign loW = CMD_W'($signed(lower_r)); // R08
  assign upDeg = normDeg(upW); // R04 R05 R06
  assign loDeg = normDeg(loW); // R04 R05 R06
  assign degMode = (positionUnitSelect == UNIT_DEG);
  assign modeOk = (opMode == MODE_CSP) || (opMode == MODE_PP)
                || (opMode == MODE_PT) || (opMode == MODE_JOG); // R15

  // Enable table: linear needs max above min, degree needs them unequal
  always_comb begin
    if (!modeOk) begin
      active = 1'b0; // R15
    end else if (degMode) begin
      active = (upDeg != loDeg); // R03
    end else begin
      active = (upW > loW); // R02 R12
    end
  end

  // Linear clamp
  logic linHi;
  logic linLo;
  assign linHi = active && !degMode && (cmdPos > upW); // R10
  assign linLo = active && !degMode && (cmdPos < loW); // R09

  // Degree arc handling on command and current position
  logic signed [CMD_W-1:0] cmdDeg;
  logic signed [CMD_W-1:0] curDeg;
  logic signed [CMD_W-1:0] distFwd;
  logic signed [CMD_W-1:0] distBack;
  logic signed [CMD_W-1:0] curFwd;
  logic signed [CMD_W-1:0] curBack;
  logic signed [CMD_W-1:0] curW;
  logic cmdOut;
  logic curOut;
  logic curWayFwd;
  logic degBlock;
  logic degHi;
  logic degLo;
  assign curW = CMD_W'(curPos);
  assign cmdDeg = normDeg(cmdPos);
  assign curDeg = normDeg(curW);
  assign distFwd = normDeg(loDeg - cmdDeg);
  assign distBack = normDeg(cmdDeg - upDeg);
  assign curFwd = normDeg(loDeg - curDeg);
  assign curBack = normDeg(curDeg - upDeg);
  assign cmdOut = active && degMode && !inArc(cmdDeg, loDeg, upDeg); // R03
  assign curOut = active && degMode && !inArc(curDeg, loDeg, upDeg);
  assign curWayFwd = (curFwd < curBack); // R07
  // Mover outside the arc may only head the short way home
  assign degBlock = curOut && (curWayFwd ? (cmdPos < curW) : (cmdPos > curW)); // R07
  assign degHi = cmdOut && !degBlock && (distBack <= distFwd); // R10
  assign degLo = cmdOut && !degBlock && (distBack > distFwd); // R09

  // Next command value before narrowing
  logic signed [CMD_W-1:0] nextPos;
  always_comb begin
    if (linHi) begin
      nextPos = upW; // R10
    end else if (linLo) begin
      nextPos = loW; // R09
    end else if (degBlock) begin
      nextPos = curW; // R07
    end else if (degHi) begin
      nextPos = cmdPos - distBack; // R10
    end else if (degLo) begin
      nextPos = cmdPos + distFwd; // R09
    end else begin
      nextPos = cmdPos;
    end
  end

  // Range check: 32-bit span always, 30-bit overshoot while linear limits apply
  logic signed [CMD_W-1:0] overHi;
  logic signed [CMD_W-1:0] overLo;
  logic rangeBad;
  assign overHi = cmdPos - upW;
  assign overLo = cmdPos - loW;
  assign rangeBad = (cmdPos > CMD32_MAX) || (cmdPos < CMD32_MIN)
                  || (active && !degMode && (overHi > OVER30_MAX))
                  || (active && !degMode && (overLo < OVER30_MIN)); // R14

  // Clamp warning state
  always_comb begin
    warn_nxt = warn_r;
    if (cmdValid) begin
      unique case (warn_r)
        WARN_NONE: begin
          if (linHi || degHi) begin
            warn_nxt = WARN_POS; // R13
          end else if (linLo || degLo || degBlock) begin
            warn_nxt = WARN_NEG; // R13
          end
        end
        WARN_POS: begin
          // A blocked degree move reports on the negative side like a low clamp
          if (linLo || degLo || degBlock) begin
            warn_nxt = WARN_NEG; // R13
          end else if (!active || (!linHi && !degHi && cmdPos < prevCmd_r)) begin
            warn_nxt = WARN_NONE; // R13
          end
        end
        WARN_NEG: begin
          if (linHi || degHi) begin
            warn_nxt = WARN_POS;
          end else if (!active || (!linLo && !degLo && !degBlock && cmdPos > prevCmd_r)) begin
            warn_nxt = WARN_NONE; // R13
          end
        end
        default: warn_nxt = WARN_NONE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      warn_r <= WARN_NONE;
    end else begin
      warn_r <= warn_nxt;
    end
  end

  // Previous command, reference for reverse-direction detection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prevCmd_r <= 40'sh00_0000_0000;
    end else if (cmdValid) begin
      prevCmd_r <= cmdPos;
    end
  end

  // One evaluation per command update, result one cycle later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      outValid_r <= 1'b0;
      outPos_r <= 32'sh0000_0000;
      posHit_r <= 1'b0;
      negHit_r <= 1'b0;
    end else begin
      outValid_r <= cmdValid; // R16
      if (cmdValid) begin
        outPos_r <= nextPos[POS_W-1:0]; // R16
        posHit_r <= linHi || degHi;
        negHit_r <= linLo || degLo || degBlock;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      limitActive_r <= 1'b0;
    end else begin
      limitActive_r <= active;
    end
  end

  // Alarm is sticky; a new fault beats a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarm_r <= 1'b0;
      homeErase_r <= 1'b0;
    end else begin
      homeErase_r <= cmdValid && rangeBad && !alarm_r; // R14
      if (cmdValid && rangeBad) begin
        alarm_r <= 1'b1; // R14
      end else if (alarmClr) begin
        alarm_r <= 1'b0;
      end
    end
  end

  assign upperPositionLimitSetting = upper_r;
  assign lowerPositionLimitSetting = lower_r;
  assign outValid = outValid_r;
  assign outPos = outPos_r;
  assign limitActive = limitActive_r;
  assign positiveLimitSymbol = posHit_r;
  assign negativeLimitSymbol = negHit_r;
  assign limitClampWarning = (warn_r != WARN_NONE);
  assign commandRangeAlarm = alarm_r;
  assign homeErase = homeErase_r;

endmodule : swpl_limit
`default_nettype wire

//--- core/swpl_pkg.sv
// Package of constants and types for the software position limit block
package swpl_pkg;

  // Widths
  localparam int POS_W = 32;
  localparam int CMD_W = 40;

  // Limit setting reset values
  localparam logic [POS_W-1:0] UPPER_LIMIT_RST = 32'h0000_0000;
  localparam logic [POS_W-1:0] LOWER_LIMIT_RST = 32'h0000_0000;

  // Parameter write selector
  localparam logic PAR_SEL_UPPER = 1'h0;
  localparam logic PAR_SEL_LOWER = 1'h1;

  // Motion-profile object holding the two limits
  localparam logic [15:0] OBJ_LIMIT_INDEX = 16'h607D;
  localparam logic [7:0] OBJ_SUB_MIN = 8'h01;
  localparam logic [7:0] OBJ_SUB_MAX = 8'h02;

  // Position unit selector codes
  localparam logic [3:0] UNIT_MM = 4'h0;
  localparam logic [3:0] UNIT_INCH = 4'h1;
  localparam logic [3:0] UNIT_DEG = 4'h2;
  localparam logic [3:0] UNIT_PULSE = 4'h3;

  // One turn in 0.001 degree steps (360.000 degrees)
  localparam logic signed [CMD_W-1:0] DEG_TURN = 40'sh00_0005_7E40;

  // Command range checks: 32-bit span and 30-bit overshoot span
  localparam logic signed [CMD_W-1:0] CMD32_MAX = 40'sh00_7FFF_FFFF;
  localparam logic signed [CMD_W-1:0] CMD32_MIN = 40'shFF_8000_0000;
  localparam logic signed [CMD_W-1:0] OVER30_MAX = 40'sh00_1FFF_FFFF;
  localparam logic signed [CMD_W-1:0] OVER30_MIN = 40'shFF_E000_0000;

  // Operation mode codes seen by the block
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_CSP = 3'h1;
  localparam logic [2:0] MODE_PP = 3'h2;
  localparam logic [2:0] MODE_PT = 3'h3;
  localparam logic [2:0] MODE_JOG = 3'h4;
  localparam logic [2:0] MODE_HOMING = 3'h5;

  // Clamp warning state
  typedef enum logic [2:0] {
    WARN_NONE = 3'b001,
    WARN_POS = 3'b010,
    WARN_NEG = 3'b100
  } swpl_warn_t;

endpackage : swpl_pkg

//--- verification/swpl_ctrl_model.sv
// Motion controller model: limit object writes and command updates
`timescale 1ns/1ns
`default_nettype none
module swpl_ctrl_model (
  // Clock
  input wire logic core_clk,
  // Object writes
  output logic objWrEn,
  output logic [15:0] objWrIndex,
  output logic [7:0] objWrSub,
  output logic [31:0] objWrData,
  // Commands
  output logic cmdValid,
  output logic signed [39:0] cmdPos
);
  initial begin
    objWrEn = 1'h0;
    objWrIndex = 16'h0000;
    objWrSub = 8'h00;
    objWrData = 32'h0000_0000;
    cmdValid = 1'h0;
    cmdPos = 40'sh00_0000_0000;
  end
  task automatic obj(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input int g);
    repeat (g) @(posedge core_clk);
    @(posedge core_clk);
    #1 objWrEn = 1'h1;
    objWrIndex = i;
    objWrSub = s;
    objWrData = d;
    @(posedge core_clk);
    #1 objWrEn = 1'h0;
    // Released lines must not look like a held value
    objWrSub = ~s;
    objWrData = ~d;
  endtask : obj
  task automatic cmd(input logic signed [39:0] p, input int g);
    repeat (g) @(posedge core_clk);
    @(posedge core_clk);
    #1 cmdValid = 1'h1;
    cmdPos = p;
    @(posedge core_clk);
    #1 cmdValid = 1'h0;
    cmdPos = ~p;
  endtask : cmd
endmodule : swpl_ctrl_model
`default_nettype wire

//--- verification/swpl_limit_props.sv
// Checker of the software position limit port behaviour
`timescale 1ns/1ns
`default_nettype none
module swpl_limit_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Object writes
  input wire logic objWrEn,
  input wire logic [15:0] objWrIndex,
  input wire logic [7:0] objWrSub,
  input wire logic [swpl_pkg::POS_W-1:0] objWrData,
  // Settings and context
  input wire logic [swpl_pkg::POS_W-1:0] upperPositionLimitSetting,
  input wire logic [swpl_pkg::POS_W-1:0] lowerPositionLimitSetting,
  input wire logic [3:0] positionUnitSelect,
  input wire logic [2:0] opMode,
  // Command path
  input wire logic cmdValid,
  input wire logic signed [swpl_pkg::CMD_W-1:0] cmdPos,
  input wire logic outValid,
  input wire logic signed [swpl_pkg::POS_W-1:0] outPos,
  // Status
  input wire logic positiveLimitSymbol,
  input wire logic negativeLimitSymbol,
  input wire logic limitClampWarning,
  input wire logic commandRangeAlarm,
  input wire logic homeErase
);
  import swpl_pkg::*;
  wire logic signed [POS_W-1:0] hi = upperPositionLimitSetting;
  wire logic signed [POS_W-1:0] lo = lowerPositionLimitSetting;
  wire logic [POS_W-1:0] cmdLow = cmdPos[POS_W-1:0];
  wire logic lin = positionUnitSelect != UNIT_DEG;
  wire logic in32 = cmdPos >= CMD32_MIN && cmdPos <= CMD32_MAX;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_OUT_LATENCY: assert property (!$past(rst) |-> outValid == $past(cmdValid))
    else $error("outValid not one cycle after cmdValid");
  AST_RESET_ZERO: assert property ($past(rst) |-> hi == '0 && lo == '0 && !outValid)
    else $error("settings or output not cleared by reset");
  AST_OBJ_MAX: assert property (objWrEn && objWrIndex == OBJ_LIMIT_INDEX
    && objWrSub == OBJ_SUB_MAX |=> hi == $past(objWrData)) else $error("upper write missed");
  AST_OBJ_MIN: assert property (objWrEn && objWrIndex == OBJ_LIMIT_INDEX
    && objWrSub == OBJ_SUB_MIN |=> lo == $past(objWrData)) else $error("lower write missed");
  AST_CLAMP_MAX: assert property (outValid && positiveLimitSymbol && $past(lin)
    && $stable(hi) |-> outPos == hi) else $error("upper clamp value wrong");
  AST_CLAMP_MIN: assert property (outValid && negativeLimitSymbol && $past(lin)
    && $stable(lo) |-> outPos == lo) else $error("lower clamp value wrong");
  AST_HOMING_PASS: assert property (cmdValid && opMode == MODE_HOMING
    |=> outPos == $past(cmdLow)) else $error("homing command altered");
  AST_LINEAR_OFF: assert property (cmdValid && lin && in32 && hi <= lo
    |=> outPos == $past(cmdLow)) else $error("inactive limit altered command");
  AST_ALARM_SET: assert property (cmdValid && !in32 && opMode inside {[1:4]}
    |=> commandRangeAlarm) else $error("range alarm missing");
  AST_HOME_ERASE: assert property ($rose(commandRangeAlarm) |-> homeErase)
    else $error("home not erased with alarm");
  AST_WARN: assert property (outValid && (positiveLimitSymbol || negativeLimitSymbol)
    |-> limitClampWarning) else $error("clamp without warning");
  cover property (outValid && positiveLimitSymbol);
  cover property (outValid && negativeLimitSymbol);
  cover property (commandRangeAlarm && homeErase);
endmodule : swpl_limit_props
bind swpl_limit swpl_limit_props u_props (.*);
`default_nettype wire

//--- verification/swpl_limit_tb.sv
// Testbench of the software position limit against a reference model
`timescale 1ns/1ns
`default_nettype none
module swpl_limit_tb;
  import swpl_pkg::*;
  logic core_clk, rst, parWrEn, parWrSel, alarmClr;
  logic [31:0] parWrData, upperPositionLimitSetting, lowerPositionLimitSetting;
  logic [3:0] positionUnitSelect;
  logic [2:0] opMode;
  logic signed [31:0] curPos, outPos;
  logic outValid, limitActive, positiveLimitSymbol, negativeLimitSymbol;
  logic limitClampWarning, commandRangeAlarm, homeErase;
  wire objWrEn, cmdValid;
  wire [15:0] objWrIndex;
  wire [7:0] objWrSub;
  wire [31:0] objWrData;
  wire signed [39:0] cmdPos;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  longint hiS, loS;
  longint prevC = 0;
  int wS = 0;
  bit eP, eN, eA;
  swpl_limit uut (.*);
  swpl_ctrl_model m (.*);
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end
  task automatic results();
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic longint fd(longint x);
    return ((x % DEG_TURN) + DEG_TURN) % DEG_TURN;
  endfunction : fd
  function automatic bit arc(longint p, longint lo, longint hi);
    return (lo <= hi) ? (p >= lo && p <= hi) : (p >= lo || p <= hi);
  endfunction : arc
  // Expected command; also sets the expected clamp symbols and enable
  function automatic longint ex(longint c);
    longint h, l, u, q, du, dl;
    h = fd(hiS);
    l = fd(loS);
    u = fd(c);
    q = fd(curPos);
    du = fd(u - h);
    dl = fd(l - u);
    eP = 1'b0;
    eN = 1'b0;
    eA = (opMode inside {[1:4]})
         && ((positionUnitSelect == UNIT_DEG) ? h != l : hiS > loS);
    if (!eA) return c;
    if (positionUnitSelect != UNIT_DEG) begin
      eP = c > hiS;
      eN = c < loS;
      return eP ? hiS : eN ? loS : c;
    end
    if (!arc(q, l, h) && ((fd(l - q) < fd(q - h)) ? c < curPos : c > curPos)) begin
      eN = 1'b1;
      return curPos;
    end
    if (arc(u, l, h)) return c;
    eP = du <= dl;
    eN = !eP;
    return eP ? c - du : c + dl;
  endfunction : ex
  task automatic rb();
    chk(upperPositionLimitSetting, 32'(hiS));
    chk(lowerPositionLimitSetting, 32'(loS));
  endtask : rb
  task automatic setObj(input logic [7:0] s, input logic signed [31:0] d);
    m.obj(OBJ_LIMIT_INDEX, s, d, $urandom % 3);
    if (s == OBJ_SUB_MAX) hiS = d;
    else loS = d;
    rb();
  endtask : setObj
  task automatic setPar(input logic s, input logic signed [31:0] d);
    @(posedge core_clk);
    #1 parWrEn = 1'h1;
    parWrSel = s;
    parWrData = d;
    @(posedge core_clk);
    #1 parWrEn = 1'h0;
    parWrData = ~d;
    if (s == PAR_SEL_UPPER) hiS = d;
    else loS = d;
    rb();
  endtask : setPar
  task automatic doCmd(input longint p);
    longint e;
    m.cmd(40'(p), $urandom % 3);
    e = ex(p);
    case (wS)
      0: wS = eP ? 1 : eN ? 2 : 0;
      1: wS = eN ? 2 : (!eA || (!eP && p < prevC)) ? 0 : 1;
      default: wS = eP ? 1 : (!eA || (!eN && p > prevC)) ? 0 : 2;
    endcase
    prevC = p;
    chk({31'h0, outValid}, 32'h1);
    chk(outPos, 32'(e));
    chk({30'h0, positiveLimitSymbol, negativeLimitSymbol}, {30'h0, eP, eN});
    chk({31'h0, limitActive}, {31'h0, eA});
    chk({31'h0, limitClampWarning}, {31'h0, wS != 0});
  endtask : doCmd
  initial begin
    void'($urandom(17365));
    rst = 1'h1;
    parWrEn = 1'h0;
    parWrSel = 1'h0;
    parWrData = 32'h0000_0000;
    alarmClr = 1'h0;
    positionUnitSelect = UNIT_MM;
    opMode = MODE_CSP;
    curPos = 32'sh0000_0000;
    hiS = 0;
    loS = 0;
    repeat (6) @(posedge core_clk);
    #1 rst = 1'h0;
    rb();
    setObj(OBJ_SUB_MAX, 32'sh0000_03E8);
    setObj(OBJ_SUB_MIN, -32'sh0000_03E8);
    m.obj(16'h607C, OBJ_SUB_MAX, 32'h0000_7777, 0);
    rb();
    for (int k = 0; k < 3; k++) begin
      positionUnitSelect = (k == 2) ? UNIT_PULSE : 4'(k);
      doCmd(64'sh1388);
      doCmd(-64'sh1388);
      doCmd(64'sh00C8);
    end
    setPar(PAR_SEL_LOWER, 32'sh0000_07D0);
    doCmd(64'sh1388);
    setPar(PAR_SEL_UPPER, 32'sh0000_07D0);
    doCmd(-64'sh1388);
    setPar(PAR_SEL_UPPER, 32'sh0000_03E8);
    setPar(PAR_SEL_LOWER, -32'sh0000_03E8);
    repeat (24) begin
      opMode = 3'($urandom % 6);
      positionUnitSelect = ($urandom % 2) ? UNIT_INCH : UNIT_PULSE;
      doCmd(longint'($urandom % 8192) - 4096);
    end
    opMode = MODE_PP;
    positionUnitSelect = UNIT_DEG;
    setObj(OBJ_SUB_MIN, -32'sh0006_2E08);
    setObj(OBJ_SUB_MAX, 32'sh0006_DDD0);
    doCmd(64'sh3_0D40);
    doCmd(64'sh3_D090);
    doCmd(64'sh0);
    doCmd(64'shE_09C0);
    setObj(OBJ_SUB_MIN, -32'sh0000_AFC8);
    doCmd(64'sh3_D090);
    setObj(OBJ_SUB_MAX, 32'sh0004_CE78);
    doCmd(64'sh3_D090);
    setObj(OBJ_SUB_MAX, 32'sh0001_5F90);
    curPos = 32'sh0002_BF20;
    doCmd(64'sh3_0D40);
    doCmd(64'sh1_86A0);
    curPos = 32'sh0004_1EB0;
    doCmd(64'sh3_D090);
    doCmd(64'sh4_93E0);
    positionUnitSelect = UNIT_MM;
    opMode = MODE_JOG;
    m.cmd(40'sh01_0000_0000, 0);
    chk({31'h0, commandRangeAlarm}, 32'h1);
    alarmClr = 1'h1;
    @(posedge core_clk);
    #1 alarmClr = 1'h0;
    chk({31'h0, commandRangeAlarm}, 32'h0);
    results();
  end
endmodule : swpl_limit_tb
`default_nettype wire
